/* mapc_skid.sv */
`timescale 1ns/10ps
`default_nettype none

package mapc_pkg;
    localparam int NCH = 8;
    localparam int DW  = 24;
    localparam int CW  = 3;

    localparam logic [1:0] MODE_HS = 2'h0;
    localparam logic [1:0] MODE_HR = 2'h1;
    localparam logic [1:0] MODE_LP = 2'h2;
    localparam logic [1:0] MODE_LS = 2'h3;

    localparam logic [2:0] FMT_SPI_DYN = 3'h0;
    localparam logic [2:0] FMT_SPI_FIX = 3'h1;
    localparam logic [2:0] FMT_SPI_DIS = 3'h2;
    localparam logic [2:0] FMT_FS_DYN  = 3'h3;
    localparam logic [2:0] FMT_FS_FIX  = 3'h4;
    localparam logic [2:0] FMT_FS_DIS  = 3'h5;
    localparam logic [2:0] FMT_MOD     = 3'h6;

    localparam logic [11:0] RATIO_256  = 12'h100;
    localparam logic [11:0] RATIO_512  = 12'h200;
    localparam logic [11:0] RATIO_2560 = 12'hA00;
    localparam logic [11:0] RATIO_RST  = 12'h100;

    localparam logic [7:0] OSR_64  = 8'h40;
    localparam logic [7:0] OSR_128 = 8'h80;

    // whole periods counted; the partial period of the change adds the spread
    localparam logic [7:0] SETTLE_SPI = 8'h80;
    localparam logic [7:0] SETTLE_FS  = 8'h7F;
    localparam logic [7:0] WAKE_SPI   = 8'h81;
    localparam logic [7:0] WAKE_FS    = 8'h80;

    typedef struct packed {
        logic [CW-1:0] chan;
        logic [DW-1:0] data;
    } mapc_word_type;

    typedef struct packed {
        logic           shift_n;
        logic           strobe;
        logic [NCH-1:0] sleep_n;
        logic [2:0]     fmt;
        logic           div;
        logic [1:0]     mode;
    } mapc_pins_type;
endpackage

module mapc_skid #(
    parameter int W = 27
) (
    input  wire logic         clk,       // system clock
    input  wire logic         rst_b,     // async reset, active low
    input  wire logic         in_valid,  // word offered
    output logic              in_ready,  // room for a word
    input  wire logic [W-1:0] in_data,   // word offered
    output logic              out_valid, // word held at output
    input  wire logic         out_ready, // receiver takes word
    output logic [W-1:0]      out_data   // word at output
);
    typedef struct packed {
        logic [W-1:0] out;
        logic         out_v;
        logic [W-1:0] skid;
        logic         skid_v;
    } mapc_skid_state_type;

    mapc_skid_state_type q;
    mapc_skid_state_type d;

    // ready is a flop so the producer never sees a combinational path from the receiver
    assign in_ready  = !q.skid_v;
    assign out_valid = q.out_v;
    assign out_data  = q.out;

    always_comb
    begin
        d = q;
        if (!q.out_v || out_ready)
        begin
            if (q.skid_v)
            begin
                d.out    = q.skid;
                d.out_v  = 1'b1;
                d.skid_v = 1'b0;
            end
            else
            begin
                d.out   = in_data;
                d.out_v = in_valid;
            end
        end
        else if (in_valid && !q.skid_v)
        begin
            d.skid   = in_data;
            d.skid_v = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            q <= '0;
        else
            q <= d;
    end

    skid_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("held word changed under stall");
    skid_full_a: assert property (@(posedge clk) disable iff (!rst_b)
        !in_ready |-> out_valid)
        else $error("skid full while output empty");
endmodule

`default_nettype wire

/* mapc_top.sv */
// Operation
// - modulator oversampling is 64, except 128 in high-resolution mode
// - master clocks per word: 256, 512, 512/256, 2560/512 by mode and divider
// - mode pins: 00 high-speed, 01 high-res, 10 low-power, 11 low-speed
// - mode pins watched continuously; changes applied without reset
// - SPI: ready stays high after mode change, at most 129 periods
// - frame-sync: data held low after mode change 127 to 128 periods
// - each channel sleeps independently by its own active-low input
// - all channels asleep: biases off, outputs still driven
// - SPI with all channels asleep forces the ready pin high
// - SPI: woken channel has valid data 129 to 130 periods later
// - frame-sync: woken channel valid 128 to 129 periods later
// - running channels are undisturbed by others sleeping or waking
// - channels woken together restart filters together, no sync pulse
// - sleeping channel gives zeros in fixed and discrete; dynamic packs
// - dynamic frame stays packed until a woken channel's data is ready
// - format 000 SPI dynamic, 001 SPI fixed, 010 SPI discrete
// - output rate scales with the master clock down to 0.1 MHz
// - all modulators share one clock; filters start on the same cycle
// - formats 011/100/101 frame-sync dynamic/fixed/discrete, 110 modulator
// - shared pin is ready output in SPI, frame strobe input otherwise
`timescale 1ns/10ps
`default_nettype none

module mapc_top (
    input  wire logic                                    clk,                  // master clock
    input  wire logic                                    rst_b,                // async reset, active low
    input  wire logic [1:0]                              mode_sel,             // operating mode pins
    input  wire logic                                    clock_divide_select,  // divider select pin
    input  wire logic [2:0]                              layout_sel,           // output format pins
    input  wire logic [mapc_pkg::NCH-1:0]                channel_sleep_n,      // per-channel sleep pins
    input  wire logic                                    ready_or_frame_pin_i, // shared pin level
    output logic                                         ready_or_frame_pin_o, // shared pin drive
    output logic                                         ready_or_frame_pin_oe,// shared pin enable
    input  wire logic                                    shift_clk_low_n,      // low while shift clock low
    input  wire logic [mapc_pkg::NCH-1:0][mapc_pkg::DW-1:0] chan_data,         // filter results
    output logic [mapc_pkg::NCH-1:0]                     chan_run,             // modulator enables
    output logic [mapc_pkg::NCH-1:0]                     filter_restart,       // filter restart pulses
    output logic                                         conv_start,           // convolution start pulse
    output logic [7:0]                                   osr,                  // oversampling ratio
    output logic                                         bias_enable,          // internal biases on
    output logic                                         data_valid_mark,      // data lines may show 1
    output logic                                         sample_ready_n,       // ready, active low
    output logic                                         word_valid,           // stream word valid
    input  wire logic                                    word_ready,           // serializer takes word
    output mapc_pkg::mapc_word_type                      word                  // stream word
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EMIT = 2'b10
    } mapc_fsm_type;

    typedef struct packed {
        mapc_pkg::mapc_pins_type              s1;
        mapc_pkg::mapc_pins_type              s2;
        logic                                 strobe_prev;
        logic                                 shift_prev;
        logic [1:0]                           mode_prev;
        logic                                 div_prev;
        logic [11:0]                          ratio;
        logic [11:0]                          cnt;
        logic [7:0]                           settle;
        logic [mapc_pkg::NCH-1:0]             run;
        logic [mapc_pkg::NCH-1:0][7:0]        wake;
        logic [mapc_pkg::NCH-1:0]             pend;
        logic [mapc_pkg::NCH-1:0]             restart;
        logic                                 conv;
        logic [7:0]                           osr;
        logic                                 bias;
        logic                                 pin_oe;
        logic                                 mark;
        logic                                 ready_n;
        mapc_fsm_type                         fsm;
        logic [mapc_pkg::CW-1:0]              slot;
        logic                                 dyn;
    } mapc_state_type;

    mapc_state_type          q;
    mapc_state_type          d;
    mapc_pkg::mapc_pins_type pins;
    mapc_pkg::mapc_word_type push_word;
    logic                    push_valid;
    logic                    push_ready;
    logic                    spi;
    logic                    fs;
    logic                    tick;
    logic                    fresh;
    logic                    all_off;
    logic [11:0]             ratio_new;
    logic [mapc_pkg::NCH-1:0] chan_ok;

    assign pins = '{shift_n: shift_clk_low_n, strobe: ready_or_frame_pin_i, sleep_n: channel_sleep_n,
                    fmt: layout_sel, div: clock_divide_select, mode: mode_sel};

    function automatic logic [11:0] mapc_ratio(input logic [1:0] m, input logic dv);
        logic [11:0] r;
        r = mapc_pkg::RATIO_256;
        unique case (m)
            mapc_pkg::MODE_HS: r = mapc_pkg::RATIO_256;
            mapc_pkg::MODE_HR: r = mapc_pkg::RATIO_512;
            mapc_pkg::MODE_LP: r = dv ? mapc_pkg::RATIO_512 : mapc_pkg::RATIO_256;
            mapc_pkg::MODE_LS: r = dv ? mapc_pkg::RATIO_2560 : mapc_pkg::RATIO_512;
        endcase
        return r;
    endfunction

    always_comb
    begin
        d         = q;
        d.s1      = pins;
        d.s2      = q.s1;
        // format decode: SPI for 000..010, frame-sync for 011..101
        spi       = (q.s2.fmt <= mapc_pkg::FMT_SPI_DIS);
        fs        = (q.s2.fmt >= mapc_pkg::FMT_FS_DYN) && (q.s2.fmt <= mapc_pkg::FMT_FS_DIS);
        all_off   = ~|q.run;
        ratio_new = mapc_ratio(q.s2.mode, q.s2.div);
        // frame-sync takes the period from the strobe edge, SPI from the counter
        tick      = fs ? (q.s2.strobe && !q.strobe_prev) : (q.cnt == q.ratio - 12'h001);
        fresh     = tick && (q.settle == 8'h00) && !all_off;
        push_valid = 1'b0;
        push_word  = '0;

        d.strobe_prev = q.s2.strobe;
        d.shift_prev  = q.s2.shift_n;
        d.mode_prev   = q.s2.mode;
        d.div_prev    = q.s2.div;
        d.cnt         = tick ? 12'h000 : q.cnt + 12'h001;
        d.conv        = tick;
        d.restart     = '0;
        d.osr         = (q.s2.mode == mapc_pkg::MODE_HR) ? mapc_pkg::OSR_128 : mapc_pkg::OSR_64;
        d.pin_oe      = spi;
        d.bias        = !all_off;

        if (tick && q.settle != 8'h00)
            d.settle = q.settle - 8'h01;
        // a mode or divider pin change reloads the ratio and restarts the settling count
        if (q.s2.mode != q.mode_prev || q.s2.div != q.div_prev)
        begin
            d.ratio  = ratio_new;
            d.cnt    = 12'h000;
            d.settle = spi ? mapc_pkg::SETTLE_SPI : mapc_pkg::SETTLE_FS;
        end

        // channels are handled alone, so a running channel never sees another's change
        for (int i = 0; i < mapc_pkg::NCH; i++)
        begin
            chan_ok[i] = q.run[i] && (q.wake[i] == 8'h00);
            if (tick && q.wake[i] != 8'h00)
                d.wake[i] = q.wake[i] - 8'h01;
            if (tick && q.pend[i])
            begin
                d.restart[i] = 1'b1;
                d.pend[i]    = 1'b0;
            end
            if (!q.s2.sleep_n[i])
            begin
                d.run[i]  = 1'b0;
                d.wake[i] = 8'h00;
                d.pend[i] = 1'b0;
            end
            else if (!q.run[i])
            begin
                d.run[i]  = 1'b1;
                d.wake[i] = spi ? mapc_pkg::WAKE_SPI : mapc_pkg::WAKE_FS;
                d.pend[i] = 1'b1;
            end
        end

        // ready pin: low on fresh data, high on first shift edge or just before next word
        if (!spi || all_off)
            d.ready_n = 1'b1;
        else if (fresh)
            d.ready_n = 1'b0;
        else if ((!q.s2.shift_n && q.shift_prev) || (q.cnt == q.ratio - 12'h002))
            d.ready_n = 1'b1;
        d.mark = fs && (q.settle == 8'h00) && !all_off;

        unique case (q.fsm)
            ST_IDLE:
            begin
                if (fresh && q.s2.fmt != mapc_pkg::FMT_MOD && (spi || fs))
                begin
                    d.fsm  = ST_EMIT;
                    d.slot = '0;
                    d.dyn  = (q.s2.fmt == mapc_pkg::FMT_SPI_DYN) || (q.s2.fmt == mapc_pkg::FMT_FS_DYN);
                end
            end
            ST_EMIT:
            begin
                // dynamic layout skips a slot without waiting; others wait for room
                if (q.dyn && !chan_ok[q.slot])
                    d.slot = q.slot + 3'h1;
                else if (push_ready)
                begin
                    push_valid     = 1'b1;
                    push_word.chan = q.slot;
                    push_word.data = chan_ok[q.slot] ? chan_data[q.slot] : '0;
                    d.slot         = q.slot + 3'h1;
                end
                if (d.slot == '0 && q.slot != '0)
                    d.fsm = ST_IDLE;
            end
        endcase
        // slots not yet pushed when the next conversion lands are dropped, not merged, and that conversion emits no frame
        if (q.fsm == ST_EMIT && tick)
            d.fsm = ST_IDLE;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q         <= '0;
            q.ratio   <= mapc_pkg::RATIO_RST;
            q.osr     <= mapc_pkg::OSR_64;
            q.pin_oe  <= 1'b1;
            q.ready_n <= 1'b1;
            q.fsm     <= ST_IDLE;
        end
        else
            q <= d;
    end

    mapc_skid #(
        .W ($bits(mapc_pkg::mapc_word_type))
    ) u_skid (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_word),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word)
    );

    assign chan_run              = q.run;
    assign filter_restart        = q.restart;
    assign conv_start            = q.conv;
    assign osr                   = q.osr;
    assign bias_enable           = q.bias;
    assign data_valid_mark       = q.mark;
    assign sample_ready_n        = q.ready_n;
    assign ready_or_frame_pin_o  = q.ready_n;
    assign ready_or_frame_pin_oe = q.pin_oe;

    osr_mode_a: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 (osr == ($past(q.s2.mode) == mapc_pkg::MODE_HR ? mapc_pkg::OSR_128 : mapc_pkg::OSR_64)))
        else $error("oversampling ratio does not follow mode");
    ratio_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        (q.s2.mode != q.mode_prev) |=> (q.ratio == $past(ratio_new)) && (q.cnt == 12'h000))
        else $error("ratio not reloaded on mode change");
    spi_period_a: assert property (@(posedge clk) disable iff (!rst_b)
        (conv_start && !fs && q.ratio == mapc_pkg::RATIO_256 && $stable(q.ratio)) |-> ##1 !conv_start [*8])
        else $error("conversion pulses too close together");
    settle_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
        (q.settle != 8'h00) |=> ($past(spi) ? !$fell(sample_ready_n) : 1'b1))
        else $error("ready fell while settling");
    fs_mark_a: assert property (@(posedge clk) disable iff (!rst_b)
        (q.settle != 8'h00) |=> !data_valid_mark)
        else $error("valid mark during settling");
    sleep_stop_a: assert property (@(posedge clk) disable iff (!rst_b)
        !q.s2.sleep_n[0] |=> !chan_run[0])
        else $error("sleeping channel still running");
    all_off_a: assert property (@(posedge clk) disable iff (!rst_b)
        (q.run == '0) |=> !bias_enable && ($past(spi) -> sample_ready_n))
        else $error("all asleep but biases or ready wrong");
    pin_dir_a: assert property (@(posedge clk) disable iff (!rst_b)
        ##1 (ready_or_frame_pin_oe == $past(spi)))
        else $error("shared pin direction wrong");
    wake_load_a: assert property (@(posedge clk) disable iff (!rst_b)
        (q.s2.sleep_n[0] && !q.run[0] && spi) |=> (q.wake[0] == mapc_pkg::WAKE_SPI))
        else $error("wake delay not loaded");
    zero_fill_a: assert property (@(posedge clk) disable iff (!rst_b)
        (push_valid && !chan_ok[push_word.chan]) |-> (push_word.data == '0) && !q.dyn)
        else $error("asleep channel data not zero");
    restart_sync_a: assert property (@(posedge clk) disable iff (!rst_b)
        (filter_restart != '0) |-> conv_start)
        else $error("filter restart off conversion edge");

    mode_change_c: cover property (@(posedge clk) disable iff (!rst_b) q.s2.mode != q.mode_prev);
    wake_done_c: cover property (@(posedge clk) disable iff (!rst_b) $fell(q.wake[0] != 8'h00));
    stall_c: cover property (@(posedge clk) disable iff (!rst_b) word_valid && !word_ready && !push_ready);
endmodule

`default_nettype wire

/* mapc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module mapc_host_model (
    input  wire logic                    clk,           // master clock
    input  wire logic                    rst_b,         // async reset, active low
    input  wire logic                    slow,          // take one word in four
    input  wire logic                    strobe_en,     // run the frame strobe
    input  wire logic [11:0]             strobe_period, // clocks per frame
    input  wire logic                    word_valid,    // stream word valid
    input  wire mapc_pkg::mapc_word_type word,          // stream word
    output logic                         word_ready,    // host takes word
    output logic                         frame_strobe   // frame strobe drive
);
    mapc_pkg::mapc_word_type got[$];
    logic [11:0]             fs_cnt_q;
    logic [1:0]              stall_q;
    always @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fs_cnt_q     <= 12'h000;
            stall_q      <= 2'h0;
            word_ready   <= 1'b0;
            frame_strobe <= 1'b0;
        end
        else
        begin
            stall_q    <= stall_q + 2'h1;
            word_ready <= !slow || (stall_q == 2'h3);
            if (word_valid && word_ready)
                got.push_back(word);
            // a strobe period off the ratio corrupts readback; the period is the strobe_period input, fixed by the bench
            fs_cnt_q     <= (!strobe_en || fs_cnt_q == strobe_period - 12'h001) ? 12'h000 : fs_cnt_q + 12'h001;
            frame_strobe <= strobe_en && (fs_cnt_q < 12'h004);
        end
    end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                                    clk = 1'b0;
    logic                                    rst_b = 1'b0;
    logic [1:0]                              mode_sel = mapc_pkg::MODE_HS;
    logic                                    div = 1'b0;
    logic [2:0]                              layout_sel = mapc_pkg::FMT_SPI_FIX;
    logic [7:0]                              sleep_n = 8'hFF;
    logic                                    slow = 1'b1;
    logic                                    strobe_en = 1'b0;
    logic                                    shift_n = 1'b1;
    logic [mapc_pkg::NCH-1:0][mapc_pkg::DW-1:0] chan_data;
    logic                                    pin_i, pin_o, pin_oe, frame_strobe, word_valid, word_ready;
    logic [7:0]                              chan_run, filter_restart, osr;
    logic                                    conv_start, bias_enable, valid_mark, sample_ready_n;
    mapc_pkg::mapc_word_type                 word;
    logic [22:0]                             tbl[6] = '{
        {mapc_pkg::MODE_HS, 1'b0, mapc_pkg::RATIO_256, mapc_pkg::OSR_64},
        {mapc_pkg::MODE_HR, 1'b1, mapc_pkg::RATIO_512, mapc_pkg::OSR_128},
        {mapc_pkg::MODE_LP, 1'b1, mapc_pkg::RATIO_512, mapc_pkg::OSR_64},
        {mapc_pkg::MODE_LP, 1'b0, mapc_pkg::RATIO_256, mapc_pkg::OSR_64},
        {mapc_pkg::MODE_LS, 1'b0, mapc_pkg::RATIO_512, mapc_pkg::OSR_64},
        {mapc_pkg::MODE_LS, 1'b1, mapc_pkg::RATIO_2560, mapc_pkg::OSR_64}};
    logic [11:0]                             ratio;
    logic [7:0]                              exp_osr;
    int                                      num_errors = 0;
    int                                      checks = 0;
    int                                      t, k;

    always #25 clk = ~clk;
    assign pin_i = pin_oe ? pin_o : frame_strobe;

    mapc_top mapc_top_i (.clk(clk), .rst_b(rst_b), .mode_sel(mode_sel), .clock_divide_select(div),
        .layout_sel(layout_sel), .channel_sleep_n(sleep_n), .ready_or_frame_pin_i(pin_i),
        .ready_or_frame_pin_o(pin_o), .ready_or_frame_pin_oe(pin_oe), .shift_clk_low_n(shift_n),
        .chan_data(chan_data), .chan_run(chan_run), .filter_restart(filter_restart), .conv_start(conv_start),
        .osr(osr), .bias_enable(bias_enable), .data_valid_mark(valid_mark), .sample_ready_n(sample_ready_n),
        .word_valid(word_valid), .word_ready(word_ready), .word(word));
    mapc_host_model mapc_host_model_i (.clk(clk), .rst_b(rst_b), .slow(slow), .strobe_en(strobe_en),
        .strobe_period(mapc_pkg::RATIO_256), .word_valid(word_valid), .word(word), .word_ready(word_ready),
        .frame_strobe(frame_strobe));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // counts clocks up to the next conversion start; a missing start is a mismatch
    task automatic next_tick(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (conv_start !== 1'b1 && n < 4000);
        if (n >= 4000)
            chk(32'h0, 32'h1);
    endtask

    // skips one period so the pins settle, then checks one whole frame
    task automatic chk_frame(input logic [7:0] on, input logic dyn);
        int j;
        next_tick(j);
        mapc_host_model_i.got.delete();
        next_tick(j);
        j = 0;
        for (int i = 0; i < 8; i++)
            if (on[i] || !dyn)
            begin
                chk({5'h00, mapc_host_model_i.got[j]}, {5'h00, 3'(i), on[i] ? chan_data[i] : 24'h0});
                j++;
            end
        chk(32'(mapc_host_model_i.got.size()), 32'(j));
    endtask

    task automatic finish_test();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        // the tests need about 84000 clocks; the rest is margin
        #(95000 * 50);
        num_errors++;
        finish_test();
    end

    initial
    begin
        for (int i = 0; i < 8; i++)
            chan_data[i] = 24'h5A0000 + 24'(i + 1);
        repeat (20) @(posedge clk);
        #1;
        chk({pin_oe, pin_o, sample_ready_n, word_valid}, 4'hE);
        rst_b = 1'b1;
        foreach (tbl[i])
        begin
            {mode_sel, div, ratio, exp_osr} = tbl[i];
            next_tick(t);
            next_tick(t);
            next_tick(t);
            chk(32'(t), {20'h0, ratio});
            chk({24'h0, osr}, {24'h0, exp_osr});
        end
        mode_sel = mapc_pkg::MODE_HS;
        div = 1'b0;
        k = 0;
        do
        begin
            next_tick(t);
            k++;
        end
        while (sample_ready_n !== 1'b0 && k < 200);
        chk(32'(k >= 128 && k <= 130), 32'h1);
        // a shift clock falling edge must release ready long before the period ends
        shift_n = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        shift_n = 1'b1;
        chk({31'h0, sample_ready_n}, 32'h1);
        chk_frame(8'hFF, 1'b0);
        sleep_n = 8'hDB;
        next_tick(t);
        chk({24'h0, chan_run}, 32'hDB);
        chk_frame(8'hDB, 1'b0);
        layout_sel = mapc_pkg::FMT_SPI_DIS;
        chk_frame(8'hDB, 1'b0);
        layout_sel = mapc_pkg::FMT_SPI_DYN;
        chk_frame(8'hDB, 1'b1);
        slow = 1'b0;
        sleep_n = 8'hFF;
        k = 0;
        do
        begin
            mapc_host_model_i.got.delete();
            next_tick(t);
            if (k == 0)
                chk({24'h0, filter_restart}, 32'h24);
            k++;
        end
        while (mapc_host_model_i.got.size() < 8 && k < 200);
        chk(32'(k >= 129 && k <= 132), 32'h1);
        chk_frame(8'hFF, 1'b1);
        sleep_n = 8'h00;
        repeat (6) @(posedge clk);
        #1;
        chk({bias_enable, sample_ready_n, pin_o, pin_oe}, 4'h7);
        chk({24'h0, chan_run}, 32'h0);
        sleep_n = 8'hFF;
        layout_sel = mapc_pkg::FMT_FS_FIX;
        strobe_en = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        chk({31'h0, pin_oe}, 32'h0);
        next_tick(t);
        next_tick(t);
        next_tick(t);
        chk(32'(t), 32'h100);
        chk({31'h0, valid_mark}, 32'h1);
        finish_test();
    end
endmodule
`default_nettype wire
